// ==== src/pcor_consts.vh ====
// Purpose: Constants for the configuration and override register group.
// Assumes: Command-code register access, 8-bit codes, 200 MHz clock.
// Notes: Definitions only.
`ifndef PCOR_CONSTS_VH
`define PCOR_CONSTS_VH
`define PCOR_CMD_STRAP 8'hee
`define PCOR_CMD_ADDR 8'hef
`define PCOR_CMD_CRC 8'hf0
`define PCOR_CMD_FINJ 8'hf1
`define PCOR_B_STACK 12
`define PCOR_B_SYNC 11
`define PCOR_B_COMP 9
`define PCOR_B_ADDR 8
`define PCOR_B_PHASE 5
`define PCOR_B_SOFT 3
`define PCOR_B_OC 2
`define PCOR_B_RATE 1
`define PCOR_B_OUTPUT_VOLTAGE_SOURCE_BIT 0
`define PCOR_STRAP_MASK 16'h1fff
`define PCOR_STRAP_RST 16'h0000
`define PCOR_RSV_A0 7'h0c
`define PCOR_RSV_A1 7'h28
`define PCOR_RSV_A2 7'h37
`define PCOR_RSV_A3 7'h61
`define PCOR_CRC_POLY 16'h8005
`define PCOR_CRC_INIT 16'h0000
`define PCOR_FINJ_RST 16'h0000
`define PCOR_B_FPERSIST 15
`define PCOR_B_WPERSIST 7
`define PCOR_FAULT_MASK 16'h5f00
`define PCOR_WARN_MASK 16'h001b
`define PCOR_B_INJ_LOCK 11
`define PCOR_B_INJ_OVF 8
`define PCOR_SET_WORDS 16
`endif

// ==== src/pcor_regs.v ====
// Purpose: Configuration override, bus address, checksum and fault injection.
// Assumes: A bus engine presents decoded command codes with strobes.
// Notes: Settings reload from the registered strap word one cycle after the boot or restore pulse.
`timescale 1ns/1ps
`include "pcor_consts.vh"
// Overview of operation
// - Bit 12 selects stack setting source.
// - Bit 11 selects clock sync source.
// - Bit 9 selects compensation source.
// - Bit 8 selects bus address source.
// - Bit 5 selects phase offset source.
// - Bit 3 selects soft start source.
// - Bit 2 selects both overcurrent thresholds.
// - Bit 1 selects switching rate source.
// - Bit 0 selects output voltage group source.
// - New address takes effect at the end of the transfer.
// - Address bit 7 reads zero.
// - Reserved addresses are refused.
// - Address uses single-byte transactions.
// - Checksum is CRC-16, polynomial 0x8005.
// - Checksum recomputed at boot, store, restore.
// - Checksum is read-only, two-byte read.
// - Injection bits force detector outputs.
// - Bit 15 makes injected faults persist.
// - Bit 7 makes injected warnings persist.
// - Only lockout, overvoltage inject while disabled.
module pcor_regs #(
    parameter SET_WORDS = `PCOR_SET_WORDS,
    parameter SET_AW = 4
) (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Command register access
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [1:0] cmd_nbytes,
    input wire xfer_done,
    output reg [15:0] cmd_rdata,
    output reg cmd_ack,
    output reg invalid_data_r,
    input wire invalid_data_clr,
    // Address match
    input wire [6:0] addr_probe,
    output wire addr_match,
    output reg [6:0] bus_addr_r,
    // Power-up and restore control
    input wire boot,
    input wire restore,
    input wire store,
    input wire [15:0] nvm_strap,
    // Stored settings image
    input wire set_wr,
    input wire [SET_AW-1:0] set_waddr,
    input wire [15:0] set_wdata,
    // Stored and pin-detected setting values
    input wire [3:0] nvm_stack,
    input wire [3:0] pin_stack,
    input wire [3:0] nvm_sync,
    input wire [3:0] pin_sync,
    input wire [7:0] nvm_comp,
    input wire [7:0] pin_comp,
    input wire [6:0] nvm_addr,
    input wire [6:0] pin_addr,
    input wire [3:0] nvm_phase,
    input wire [3:0] pin_phase,
    input wire [15:0] nvm_soft,
    input wire [15:0] pin_soft,
    input wire [31:0] nvm_oc,
    input wire [31:0] pin_oc,
    input wire [15:0] nvm_rate,
    input wire [15:0] pin_rate,
    input wire [63:0] nvm_output_voltage_source_bit,
    input wire [63:0] pin_output_voltage_source_bit,
    // Reloaded settings
    output reg [3:0] stack_setting_r,
    output reg [3:0] sync_setting_r,
    output reg [7:0] comp_setting_r,
    output reg [3:0] phase_offset_setting_r,
    output reg [15:0] soft_start_time_r,
    output reg [15:0] overcurrent_fault_threshold_r,
    output reg [15:0] overcurrent_warning_threshold_r,
    output reg [15:0] switching_rate_r,
    output reg [15:0] output_voltage_target_r,
    output reg [15:0] feedback_scale_r,
    output reg [15:0] output_voltage_ceiling_r,
    output reg [15:0] output_voltage_floor_r,
    // Checksum
    output reg [15:0] settings_crc_r,
    output wire crc_busy,
    // Fault detectors
    input wire conv_en,
    input wire fault_response,
    input wire warn_response,
    input wire [15:0] det_in,
    output reg [15:0] det_out_r
);
    reg [15:0] strap_r;
    reg [15:0] finj_r;
    reg [6:0] pend_addr_r;
    reg pend_r;
    reg load_r;
    reg [1:0] crc_st_r;
    reg [SET_AW:0] crc_idx_r;
    reg [15:0] crc_acc_r;
    reg [15:0] crc_word;
    reg [15:0] crc_nxt;
    reg [15:0] inj_eff;
    integer i;
    wire reload = boot | restore;
    wire [15:0] rd_word;
    wire addr_rsv;
    wire [6:0] waddr = cmd_wdata[6:0];

    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_CALC = 2'd2;

    assign addr_rsv = (waddr == `PCOR_RSV_A0) | (waddr == `PCOR_RSV_A1) |
                      (waddr == `PCOR_RSV_A2) | (waddr == `PCOR_RSV_A3);

    assign addr_match = (addr_probe == bus_addr_r);
    assign crc_busy = (crc_st_r != ST_IDLE);

    pcor_set_mem #(
        .DW(16),
        .DEPTH(SET_WORDS),
        .AW(SET_AW)
    ) u_mem (
        .mclk(mclk),
        .wr_en(set_wr),
        .wr_addr(set_waddr),
        .wr_data(set_wdata),
        .rd_addr(crc_idx_r[SET_AW-1:0]),
        .rd_data(rd_word)
    );

    // Register writes and the bus address.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_r <= `PCOR_STRAP_RST;
            bus_addr_r <= 7'h00;
            pend_addr_r <= 7'h00;
            pend_r <= 1'b0;
            invalid_data_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            load_r <= reload;
            if (reload) begin
                strap_r <= nvm_strap & `PCOR_STRAP_MASK;
            end else if (cmd_wr && cmd_code == `PCOR_CMD_STRAP) begin
                strap_r <= cmd_wdata & `PCOR_STRAP_MASK;
            end
            if (cmd_wr && cmd_code == `PCOR_CMD_ADDR &&
                (addr_rsv || cmd_nbytes != 2'd1)) begin
                invalid_data_r <= 1'b1;
            end else if (invalid_data_clr) begin
                invalid_data_r <= 1'b0;
            end
            if (pend_r && xfer_done) begin
                bus_addr_r <= pend_addr_r;
                pend_r <= 1'b0;
            end
            // Single-byte write only; a new request wins.
            if (cmd_wr && cmd_code == `PCOR_CMD_ADDR && !addr_rsv &&
                cmd_nbytes == 2'd1) begin
                pend_addr_r <= waddr;
                pend_r <= 1'b1;
            end
            if (reload) begin
                // Source bit from the reloaded strap word.
                bus_addr_r <= nvm_strap[`PCOR_B_ADDR] ? pin_addr : nvm_addr;
                pend_r <= 1'b0;
            end
        end
    end

    // Settings reload on power-up or restore.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stack_setting_r <= 4'h0;
            sync_setting_r <= 4'h0;
            comp_setting_r <= 8'h00;
            phase_offset_setting_r <= 4'h0;
            soft_start_time_r <= 16'h0000;
            overcurrent_fault_threshold_r <= 16'h0000;
            overcurrent_warning_threshold_r <= 16'h0000;
            switching_rate_r <= 16'h0000;
            output_voltage_target_r <= 16'h0000;
            feedback_scale_r <= 16'h0000;
            output_voltage_ceiling_r <= 16'h0000;
            output_voltage_floor_r <= 16'h0000;
        end else if (load_r) begin
            stack_setting_r <= strap_r[`PCOR_B_STACK] ? pin_stack : nvm_stack;
            sync_setting_r <= strap_r[`PCOR_B_SYNC] ? pin_sync : nvm_sync;
            comp_setting_r <= strap_r[`PCOR_B_COMP] ? pin_comp : nvm_comp;
            phase_offset_setting_r <= strap_r[`PCOR_B_PHASE] ?
                                      pin_phase : nvm_phase;
            soft_start_time_r <= strap_r[`PCOR_B_SOFT] ? pin_soft : nvm_soft;
            {overcurrent_fault_threshold_r, overcurrent_warning_threshold_r} <=
                strap_r[`PCOR_B_OC] ? pin_oc : nvm_oc;
            switching_rate_r <= strap_r[`PCOR_B_RATE] ? pin_rate : nvm_rate;
            {output_voltage_target_r, feedback_scale_r,
             output_voltage_ceiling_r, output_voltage_floor_r} <=
                strap_r[`PCOR_B_OUTPUT_VOLTAGE_SOURCE_BIT] ? pin_output_voltage_source_bit : nvm_output_voltage_source_bit;
        end
    end

    // CRC-16 step over one stored word, MSB first.
    always @* begin
        crc_word = crc_acc_r;
        for (i = 15; i >= 0; i = i - 1) begin
            if (crc_word[15] ^ rd_word[i]) begin
                crc_word = {crc_word[14:0], 1'b0} ^ `PCOR_CRC_POLY;
            end else begin
                crc_word = {crc_word[14:0], 1'b0};
            end
        end
        crc_nxt = crc_word;
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crc_st_r <= ST_IDLE;
            crc_idx_r <= {(SET_AW+1){1'b0}};
            crc_acc_r <= `PCOR_CRC_INIT;
            settings_crc_r <= `PCOR_CRC_INIT;
        end else begin
            case (crc_st_r)
                ST_IDLE: begin
                    if (boot || store || restore) begin
                        crc_idx_r <= {(SET_AW+1){1'b0}};
                        crc_acc_r <= `PCOR_CRC_INIT;
                        crc_st_r <= ST_READ;
                    end
                end
                ST_READ: begin
                    crc_st_r <= ST_CALC;
                end
                ST_CALC: begin
                    crc_acc_r <= crc_nxt;
                    if (crc_idx_r == SET_WORDS - 1) begin
                        settings_crc_r <= crc_nxt;
                        crc_st_r <= ST_IDLE;
                    end else begin
                        crc_idx_r <= crc_idx_r + 1'b1;
                        crc_st_r <= ST_READ;
                    end
                end
                default: crc_st_r <= ST_IDLE;
            endcase
        end
    end

    // Fault injection register and auto-clear.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            finj_r <= `PCOR_FINJ_RST;
        end else if (cmd_wr && cmd_code == `PCOR_CMD_FINJ) begin
            finj_r <= cmd_wdata;
        end else begin
            if (fault_response && !finj_r[`PCOR_B_FPERSIST]) begin
                finj_r <= finj_r & ~`PCOR_FAULT_MASK;
            end
            if (warn_response && !finj_r[`PCOR_B_WPERSIST]) begin
                finj_r <= finj_r & ~`PCOR_WARN_MASK;
            end
            if (fault_response && !finj_r[`PCOR_B_FPERSIST] &&
                warn_response && !finj_r[`PCOR_B_WPERSIST]) begin
                finj_r <= finj_r & ~(`PCOR_FAULT_MASK | `PCOR_WARN_MASK);
            end
        end
    end

    always @* begin
        inj_eff = finj_r & (`PCOR_FAULT_MASK | `PCOR_WARN_MASK);
        if (!conv_en) begin
            inj_eff = inj_eff & ((16'h0001 << `PCOR_B_INJ_LOCK) |
                                 (16'h0001 << `PCOR_B_INJ_OVF));
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            det_out_r <= 16'h0000;
        end else begin
            det_out_r <= det_in | inj_eff;
        end
    end

    // Read data and acknowledge.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmd_rdata <= 16'h0000;
            cmd_ack <= 1'b0;
        end else begin
            cmd_ack <= 1'b0;
            if (cmd_rd) begin
                cmd_ack <= 1'b1;
                case (cmd_code)
                    `PCOR_CMD_STRAP: cmd_rdata <= strap_r;
                    `PCOR_CMD_ADDR: cmd_rdata <= {9'h000, bus_addr_r};
                    `PCOR_CMD_CRC: cmd_rdata <= settings_crc_r;
                    `PCOR_CMD_FINJ: cmd_rdata <= finj_r;
                    default: begin
                        cmd_rdata <= 16'h0000;
                        cmd_ack <= 1'b0;
                    end
                endcase
            end else if (cmd_wr) begin
                cmd_ack <= (cmd_code == `PCOR_CMD_STRAP) ||
                           (cmd_code == `PCOR_CMD_FINJ) ||
                           (cmd_code == `PCOR_CMD_ADDR);
            end
        end
    end
endmodule // pcor_regs

// ==== src/pcor_set_mem.v ====
// Purpose: Small stored-settings memory, one write and one read port.
// Assumes: Read data registered, one cycle latency.
// Notes: Holds the nonvolatile settings image seen by the checksum engine.
`timescale 1ns/1ps
module pcor_set_mem #(
    parameter DW = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock
    input wire mclk,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // pcor_set_mem

// ==== tb/pcor_host.sv ====
// Purpose: Bus host model issuing command reads and writes.
// Assumes: Strobes and data change only at rising clock edges.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module pcor_host (
    // Clock
    input wire mclk,
    // Command strobes and data
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic [1:0] cmd_nbytes,
    output logic xfer_done,
    // Answer
    input wire cmd_ack,
    input wire [15:0] cmd_rdata
);
    initial {cmd_wr, cmd_rd, cmd_code, cmd_wdata, cmd_nbytes, xfer_done} = '0;
    task xfer(input logic rd, input logic [7:0] code, input logic [15:0] d,
              input logic [1:0] nb, output logic ok, output logic [15:0] q);
        int i;
        @(posedge mclk);
        {cmd_rd, cmd_wr, cmd_code, cmd_wdata, cmd_nbytes} <= {rd, !rd, code, d, nb};
        @(posedge mclk);
        {cmd_rd, cmd_wr, cmd_code, cmd_wdata} <= {2'b00, ~code, ~d};
        ok = 1'b0;
        q = 16'h0000;
        for (i = 0; i < 3 && !ok; i++) begin
            @(posedge mclk);
            if (cmd_ack === 1'b1) begin
                ok = 1'b1;
                q = cmd_rdata;
            end
        end
        xfer_done <= 1'b1;
        @(posedge mclk);
        xfer_done <= 1'b0;
    endtask
endmodule // pcor_host

// ==== tb/pcor_regs_chk.sv ====
// Purpose: Port-level assertions for the override register group.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the register group.
`timescale 1ns/1ps
`include "pcor_consts.vh"
module pcor_regs_chk (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Register access
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire xfer_done,
    input wire [15:0] cmd_rdata,
    input wire cmd_ack,
    input wire invalid_data_r,
    // Address and checksum
    input wire [6:0] addr_probe,
    input wire addr_match,
    input wire [6:0] bus_addr_r,
    input wire boot,
    input wire restore,
    input wire store,
    input wire crc_busy,
    // Detectors
    input wire conv_en,
    input wire [15:0] det_in,
    input wire [15:0] det_out_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_addr_wr;
        cmd_wr && cmd_code == `PCOR_CMD_ADDR;
    endsequence
    sequence s_rsv_wr;
        cmd_wr && cmd_code == `PCOR_CMD_ADDR && cmd_wdata[6:0] inside
            {`PCOR_RSV_A0, `PCOR_RSV_A1, `PCOR_RSV_A2, `PCOR_RSV_A3};
    endsequence
    a_addr_acked: assert property (
        s_addr_wr |=> cmd_ack) else $error("address write not acknowledged");
    a_crc_no_wr: assert property (
        cmd_wr && cmd_code == `PCOR_CMD_CRC |=> !cmd_ack)
        else $error("checksum write was acknowledged");
    a_addr_rd_top: assert property (
        cmd_rd && cmd_code == `PCOR_CMD_ADDR |=> cmd_ack && cmd_rdata[15:7] == 9'h0)
        else $error("address read upper bits not zero");
    a_rsv_flagged: assert property (
        s_rsv_wr |-> ##[1:4] invalid_data_r) else $error("reserved write not flagged");
    a_rsv_kept: assert property (
        $changed(bus_addr_r) && $past(xfer_done) |-> !(bus_addr_r inside
        {`PCOR_RSV_A0, `PCOR_RSV_A1, `PCOR_RSV_A2, `PCOR_RSV_A3}))
        else $error("reserved address taken");
    a_addr_after_done: assert property (
        $changed(bus_addr_r) |-> $past(xfer_done) || $past(boot) || $past(restore))
        else $error("address changed before transfer end");
    a_match_now: assert property (
        addr_match == (addr_probe == bus_addr_r)) else $error("address match wrong");
    a_crc_starts: assert property (
        (boot || store || restore) && !crc_busy |=> crc_busy)
        else $error("checksum did not start");
    a_crc_bounded: assert property (
        $rose(crc_busy) |-> ##[1:40] !crc_busy) else $error("checksum too long");
    a_det_passes: assert property (
        1'b1 |=> (det_out_r & $past(det_in)) == $past(det_in))
        else $error("detector input lost");
    a_off_masks: assert property (
        !conv_en && $stable(det_in) |=>
        ((det_out_r ^ $past(det_in)) & 16'h561b) == 16'h0000)
        else $error("injection acted while disabled");
endmodule // pcor_regs_chk
bind pcor_regs pcor_regs_chk u_chk (.*);

// ==== tb/pmbus_config_override_regs_test.sv ====
// Purpose: Self-checking bench for the override register group.
// Assumes: Host model drives command access; stored values are fixed.
// Notes: Ordinary cases run from a table, awkward cases follow it.
`timescale 1ns/1ps
`include "pcor_consts.vh"
module pmbus_config_override_regs_test;
    typedef struct {logic inj; logic [15:0] w; logic [6:0] a;
        logic [2:0] ctl; logic [15:0] e;} pcor_row_t;
    logic mclk = 1'b0, resetn = 1'b0, invalid_data_clr = 1'b0, ok;
    logic boot = 1'b0, restore = 1'b0, store = 1'b0, set_wr = 1'b0;
    logic conv_en = 1'b1, fault_response = 1'b0, warn_response = 1'b0;
    logic [6:0] addr_probe = 7'h00;
    logic [3:0] set_waddr = 4'h0;
    logic [15:0] nvm_strap = 16'h0000, set_wdata = 16'h0000, q, s, c;
    logic [15:0] det_in = 16'h0020;
    logic [63:0] nv = 64'h9abc_def0_1357_2415;
    wire [63:0] pn = ~nv;
    wire cmd_wr, cmd_rd, xfer_done, cmd_ack, invalid_data_r, addr_match;
    wire crc_busy;
    wire [7:0] cmd_code, comp_setting_r;
    wire [1:0] cmd_nbytes;
    wire [6:0] bus_addr_r;
    wire [3:0] stack_setting_r, sync_setting_r, phase_offset_setting_r;
    wire [15:0] cmd_wdata, cmd_rdata, soft_start_time_r, switching_rate_r;
    wire [15:0] overcurrent_fault_threshold_r, overcurrent_warning_threshold_r;
    wire [15:0] output_voltage_target_r, feedback_scale_r, settings_crc_r;
    wire [15:0] output_voltage_ceiling_r, output_voltage_floor_r, det_out_r;
    wire [147:0] got = {stack_setting_r, sync_setting_r, comp_setting_r,
        phase_offset_setting_r, soft_start_time_r, overcurrent_fault_threshold_r,
        overcurrent_warning_threshold_r, switching_rate_r, output_voltage_target_r,
        feedback_scale_r, output_voltage_ceiling_r, output_voltage_floor_r};
    int bad_count = 0, check_count = 0, i, k;
    logic [6:0] rsv [4] = '{`PCOR_RSV_A0, `PCOR_RSV_A1, `PCOR_RSV_A2, `PCOR_RSV_A3};
    pcor_row_t rows [10] = '{'{1'b0, 16'h0000, 7'h15, 3'h0, 16'h0000},
        '{1'b0, 16'h1b2f, 7'h6a, 3'h0, 16'h0000},
        '{1'b0, 16'h1025, 7'h15, 3'h0, 16'h0000},
        '{1'b0, 16'h0b0a, 7'h6a, 3'h0, 16'h0000},
        '{1'b0, 16'h0000, 7'h15, 3'h0, 16'h0000},
        '{1'b1, 16'h5f1b, 7'h00, 3'h4, 16'h5f1b},
        '{1'b1, 16'h5f1b, 7'h00, 3'h6, 16'h001b},
        '{1'b1, 16'h5f1b, 7'h00, 3'h5, 16'h5f00},
        '{1'b1, 16'hdf9b, 7'h00, 3'h7, 16'h5f1b},
        '{1'b1, 16'h5f1b, 7'h00, 3'h0, 16'h0900}};
    pcor_regs u_dut (.*, .nvm_stack(nv[3:0]), .pin_stack(pn[3:0]),
        .nvm_sync(nv[3:0]), .pin_sync(pn[3:0]), .nvm_comp(nv[7:0]),
        .pin_comp(pn[7:0]), .nvm_addr(nv[6:0]), .pin_addr(pn[6:0]),
        .nvm_phase(nv[3:0]), .pin_phase(pn[3:0]), .nvm_soft(nv[15:0]),
        .pin_soft(pn[15:0]), .nvm_oc(nv[31:0]), .pin_oc(pn[31:0]),
        .nvm_rate(nv[15:0]), .pin_rate(pn[15:0]), .nvm_output_voltage_source_bit(nv), .pin_output_voltage_source_bit(pn));
    pcor_host u_host (.*);
    initial forever #2.5 mclk = ~mclk;
    function logic [15:0] crc_word(input logic [15:0] a, input logic [15:0] d);
        for (int b = 15; b >= 0; b--)
            a = {a[14:0], 1'b0} ^ ((a[15] ^ d[b]) ? `PCOR_CRC_POLY : 16'h0000);
        return a;
    endfunction
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input string name, input logic [147:0] e, input logic [147:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task complete_run;
        $display("Checks %0d, errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task io(input logic rd, input logic [7:0] cd, input logic [15:0] d,
            input logic [1:0] nb);
        u_host.xfer(rd, cd, d, nb, ok, q);
        tick(1);
    endtask
    task wait_crc;
        for (k = 0; k < 80 && crc_busy !== 1'b0; k++) tick(1);
        if (k == 80) begin
            bad_count++;
            $display("Error checksum wait expected idle seen busy");
            complete_run;
        end
    endtask
    initial begin
        tick(12);
        resetn <= 1'b1;
        for (i = 0; i < 10; i++) begin
            s = rows[i].w;
            if (!rows[i].inj) begin
                nvm_strap <= s;
                {boot, restore} <= (i == 0) ? 2'b10 : 2'b01;
                tick(1);
                {boot, restore} <= 2'b00;
                tick(3);
                chk("settings", {s[12] ? pn[3:0] : nv[3:0], s[11] ? pn[3:0] : nv[3:0],
                    s[9] ? pn[7:0] : nv[7:0], s[5] ? pn[3:0] : nv[3:0],
                    s[3] ? pn[15:0] : nv[15:0], s[2] ? pn[31:0] : nv[31:0],
                    s[1] ? pn[15:0] : nv[15:0], s[0] ? pn : nv}, got);
                chk("reload address", rows[i].a, bus_addr_r);
                io(1'b1, `PCOR_CMD_STRAP, 16'h0000, 2'd2);
                chk("strap", s, q);
            end else begin
                conv_en <= rows[i].ctl[2];
                io(1'b0, `PCOR_CMD_FINJ, s, 2'd2);
                {fault_response, warn_response} <= rows[i].ctl[1:0];
                tick(1);
                {fault_response, warn_response} <= 2'b00;
                tick(2);
                chk("inject", rows[i].e, det_out_r & 16'h5f1b);
            end
        end
        conv_en <= 1'b1;
        io(1'b0, `PCOR_CMD_ADDR, 16'h00a2, 2'd1);
        chk("address", 7'h22, bus_addr_r);
        addr_probe <= 7'h15;
        tick(1);
        chk("old match", 1'b0, addr_match);
        addr_probe <= 7'h22;
        tick(1);
        chk("new match", 1'b1, addr_match);
        io(1'b1, `PCOR_CMD_ADDR, 16'h0000, 2'd1);
        chk("address read", 16'h0022, q);
        for (i = 0; i < 5; i++) begin
            io(1'b0, `PCOR_CMD_ADDR, (i < 4) ? {9'h0, rsv[i]} : 16'h0033,
                (i < 4) ? 2'd1 : 2'd2);
            chk("kept address", 7'h22, bus_addr_r);
            chk("invalid flag", 1'b1, invalid_data_r);
            invalid_data_clr <= 1'b1;
            tick(1);
            invalid_data_clr <= 1'b0;
        end
        io(1'b0, `PCOR_CMD_CRC, 16'h1234, 2'd2);
        chk("checksum write ack", 1'b0, ok);
        wait_crc;
        c = `PCOR_CRC_INIT;
        for (i = 0; i < 16; i++) begin
            s = 16'h3c5a ^ (i[15:0] * 16'h0b21);
            {set_wr, set_waddr, set_wdata} <= {1'b1, i[3:0], s};
            c = crc_word(c, s);
            tick(1);
        end
        {set_wr, store} <= 2'b01;
        tick(1);
        store <= 1'b0;
        tick(1);
        wait_crc;
        chk("checksum", c, settings_crc_r);
        io(1'b1, `PCOR_CMD_CRC, 16'h0000, 2'd2);
        chk("checksum read", c, q);
        complete_run;
    end
endmodule // pmbus_config_override_regs_test
